// *** include/csf_consts.svh ***
// constants for the status-flag and arithmetic-timing core
// assumes an 8-bit APB address and 32-bit data words
`ifndef CSF_CONSTS_SVH
`define CSF_CONSTS_SVH

// register byte addresses
`define CSF_ADDR_PSW   8'h00
`define CSF_ADDR_OPA   8'h04
`define CSF_ADDR_OPB   8'h08
`define CSF_ADDR_CMD   8'h0C
`define CSF_ADDR_RES   8'h10
`define CSF_ADDR_STAT  8'h14
`define CSF_ADDR_IRQ   8'h18
`define CSF_ADDR_CLK   8'h1C

// status word bit positions
`define CSF_PSW_C      0
`define CSF_PSW_Z      1
`define CSF_PSW_I      2
`define CSF_PSW_D      3
`define CSF_PSW_T      5
`define CSF_PSW_V      6
`define CSF_PSW_N      7

// reset values
`define CSF_PSW_RST    8'h04
`define CSF_IRQ_RST    8'h00
`define CSF_HS_RST     1'b0

// internal clock divide limits (osc rises per phi period minus one)
`define CSF_DIV_HS     3'h1
`define CSF_DIV_MS     3'h7

// phi cycles per operation
`define CSF_CYC_ARITH  5'h02
`define CSF_CYC_FLAG   5'h02
`define CSF_CYC_MUL    5'h0F
`define CSF_CYC_DIV    5'h10
`define CSF_CYC_BBX    5'h05

`endif

// *** include/csf_pkg.sv ***
// types for the status-flag and arithmetic-timing core
// assumes csf_consts.svh is on the include path
package csf_pkg;

  typedef enum logic [3:0] {
    add_with_carry_op       = 4'h0,
    subtract_with_borrow_op = 4'h1,
    set_carry_op            = 4'h2,
    clear_carry_op          = 4'h3,
    clear_decimal_op        = 4'h4,
    set_decimal_op          = 4'h5,
    multiply_op             = 4'h6,
    divide_op               = 4'h7,
    branch_bit_clear_op     = 4'h8,
    branch_bit_set_op       = 4'h9
  } csf_op_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } csf_state_e;

  typedef struct packed {
    csf_state_e  st;
    csf_op_e     op;
    logic [4:0]  cyc;
    logic [7:0]  psw;
    logic [7:0]  opa;
    logic [7:0]  opb;
    logic [15:0] res;
    logic [7:0]  irq;
    logic [7:0]  irq_pend;
    logic        irq_pv;
    logic        hs;
    logic [2:0]  div_cnt;
    logic        osc_m;
    logic        osc_s;
    logic        osc_d;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } csf_state_s;

endpackage

// *** verilog/csf_bcd_digit.sv ***
// one decimal digit of add or subtract with carry/borrow
// assumes operand digits are valid decimal values
`timescale 1ns/1ps

module csf_bcd_digit #(
  parameter int W = 4
) (
  // digit operands
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  input  wire logic         cin,
  input  wire logic         sub,
  // digit result
  output logic      [W-1:0] d,
  output logic              cout
);

  localparam logic [W:0] NINE = (W+1)'(9);
  localparam logic [W:0] ADJ  = (W+1)'(6);

  logic [W:0] t;

  always_comb begin
    if (sub) begin
      t    = {1'b0, a} - {1'b0, b} - {{W{1'b0}}, cin};
      cout = t[W];
      d    = t[W] ? (t[W-1:0] - ADJ[W-1:0]) : t[W-1:0];
    end else begin
      t    = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
      cout = (t > NINE);
      d    = (t > NINE) ? (t[W-1:0] + ADJ[W-1:0]) : t[W-1:0];
    end
  end

endmodule

// *** verilog/csf_core.sv ***
// status word, decimal/binary arithmetic, multiply/divide and phi timing
// assumes an APB master on clk; main_osc_input is asynchronous to clk
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
`include "csf_consts.svh"

// Contract
// - reset sets interrupt mask flag; other status bits may be anything.
// - interrupt request writes become visible after the next instruction completes.
// - decimal flag set makes add and subtract produce BCD results.
// - negative, overflow and zero flags are meaningless in decimal mode.
// - multiply and divide ignore index X mode and decimal flags.
// - multiply and divide leave the whole status word unchanged.
// - each instruction lasts its cycle count times the phi period.
// - high-speed phi period is twice the oscillator period.
module csf_core
  import csf_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // oscillator pin
  input  wire logic        main_osc_input,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // status
  output logic      [7:0]  processor_status_word,
  output logic             busy,
  output logic      [7:0]  irq_req
);

  csf_state_s s;
  csf_state_s n;

  logic        rise;
  logic        tick;
  logic        done;
  logic        is_sub;
  logic [8:0]  bin_sum;
  logic [7:0]  bcd_val;
  logic        lo_c;
  logic        hi_c;
  logic [15:0] prod;
  logic        acc;
  logic        err;
  logic [31:0] rdata;

  assign is_sub = (s.op == subtract_with_borrow_op);
  assign prod   = s.opa * s.opb;

  csf_bcd_digit #(.W(4)) u_lo (
    .a    (s.opa[3:0]),
    .b    (s.opb[3:0]),
    .cin  (is_sub ? ~s.psw[`CSF_PSW_C] : s.psw[`CSF_PSW_C]),
    .sub  (is_sub),
    .d    (bcd_val[3:0]),
    .cout (lo_c)
  );

  csf_bcd_digit #(.W(4)) u_hi (
    .a    (s.opa[7:4]),
    .b    (s.opb[7:4]),
    .cin  (lo_c),
    .sub  (is_sub),
    .d    (bcd_val[7:4]),
    .cout (hi_c)
  );

  always_comb begin
    n       = s;
    bin_sum = {1'b0, s.opa} + {1'b0, is_sub ? ~s.opb : s.opb} + {8'h00, s.psw[`CSF_PSW_C]};
    // oscillator sync and phi divider
    n.osc_m = main_osc_input;
    n.osc_s = s.osc_m;
    n.osc_d = s.osc_s;
    rise    = s.osc_s & ~s.osc_d;
    tick    = rise & (s.div_cnt >= (s.hs ? `CSF_DIV_HS : `CSF_DIV_MS));
    if (rise) begin
      n.div_cnt = tick ? 3'h0 : s.div_cnt + 3'h1;
    end
    done = (s.st == ST_RUN) & tick & (s.cyc == 5'h01);
    // instruction timing and execution
    if ((s.st == ST_RUN) && tick) begin
      n.cyc = s.cyc - 5'h01;
    end
    if (done) begin
      n.st = ST_IDLE;
      case (s.op)
        add_with_carry_op, subtract_with_borrow_op: begin
          if (s.psw[`CSF_PSW_D]) begin
            n.res                = {8'h00, bcd_val};
            n.psw[`CSF_PSW_C]    = is_sub ? ~hi_c : hi_c;
          end else begin
            n.res                = {8'h00, bin_sum[7:0]};
            n.psw[`CSF_PSW_C]    = bin_sum[8];
          end
          // flags from binary sum; not meaningful in decimal mode
          n.psw[`CSF_PSW_N] = bin_sum[7];
          n.psw[`CSF_PSW_Z] = (bin_sum[7:0] == 8'h00);
          n.psw[`CSF_PSW_V] = (~(s.opa[7] ^ (is_sub ? ~s.opb[7] : s.opb[7]))) &
                              (s.opa[7] ^ bin_sum[7]);
        end
        set_carry_op:     n.psw[`CSF_PSW_C] = 1'b1;
        clear_carry_op:   n.psw[`CSF_PSW_C] = 1'b0;
        clear_decimal_op: n.psw[`CSF_PSW_D] = 1'b0;
        set_decimal_op:   n.psw[`CSF_PSW_D] = 1'b1;
        multiply_op: begin
          n.res = prod;
        end
        divide_op: begin
          if (s.opb == 8'h00) begin
            n.res = {s.opa, 8'hFF};
          end else begin
            n.res = {s.opa % s.opb, s.opa / s.opb};
          end
        end
        branch_bit_clear_op: n.res = {15'h0000, ~s.irq[s.opa[2:0]]};
        branch_bit_set_op:   n.res = {15'h0000, s.irq[s.opa[2:0]]};
        default: n.res = s.res;
      endcase
      if (s.irq_pv) begin
        n.irq    = s.irq_pend;
        n.irq_pv = 1'b0;
      end
    end
    // apb decode
    acc   = psel & penable;
    rdata = 32'h00000000;
    err   = 1'b0;
    case (paddr)
      `CSF_ADDR_PSW:  begin rdata = {24'h000000, s.psw};          err = pwrite & (s.st == ST_RUN); end
      `CSF_ADDR_OPA:  begin rdata = {24'h000000, s.opa};          err = pwrite & (s.st == ST_RUN); end
      `CSF_ADDR_OPB:  begin rdata = {24'h000000, s.opb};          err = pwrite & (s.st == ST_RUN); end
      `CSF_ADDR_CMD:  begin rdata = {28'h0000000, s.op};          err = pwrite & (s.st == ST_RUN); end
      `CSF_ADDR_RES:  begin rdata = {16'h0000, s.res};            err = pwrite; end
      `CSF_ADDR_STAT: begin rdata = {26'h0000000, s.cyc, s.st == ST_RUN}; err = pwrite; end
      `CSF_ADDR_IRQ:  begin rdata = {24'h000000, s.irq}; end
      `CSF_ADDR_CLK:  begin rdata = {31'h00000000, s.hs}; end
      default:        err = 1'b1;
    endcase
    n.pready = acc & ~s.pready;
    if (acc && !s.pready) begin
      n.prdata  = pwrite ? 32'h00000000 : rdata;
      n.pslverr = err;
    end
    if (acc && s.pready && pwrite && !s.pslverr) begin
      case (paddr)
        `CSF_ADDR_PSW: n.psw = pwdata[7:0];
        `CSF_ADDR_OPA: n.opa = pwdata[7:0];
        `CSF_ADDR_OPB: n.opb = pwdata[7:0];
        `CSF_ADDR_CMD: begin
          n.op  = csf_op_e'(pwdata[3:0]);
          n.st  = ST_RUN;
          case (pwdata[3:0])
            4'h0, 4'h1: n.cyc = `CSF_CYC_ARITH;
            4'h6:       n.cyc = `CSF_CYC_MUL;
            4'h7:       n.cyc = `CSF_CYC_DIV;
            4'h8, 4'h9: n.cyc = `CSF_CYC_BBX;
            default:    n.cyc = `CSF_CYC_FLAG;
          endcase
        end
        `CSF_ADDR_IRQ: begin
          n.irq_pend = pwdata[7:0];
          n.irq_pv   = 1'b1;
        end
        `CSF_ADDR_CLK: n.hs = pwdata[0];
        default: n.hs = s.hs;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s          <= '0;
      s.st       <= ST_IDLE;
      s.op       <= add_with_carry_op;
      s.psw      <= `CSF_PSW_RST;
      s.irq      <= `CSF_IRQ_RST;
      s.irq_pend <= `CSF_IRQ_RST;
      s.hs       <= `CSF_HS_RST;
    end else begin
      s <= n;
    end
  end

  assign prdata                = s.prdata;
  assign pready                = s.pready;
  assign pslverr               = s.pslverr;
  assign processor_status_word = s.psw;
  assign busy                  = (s.st == ST_RUN);
  assign irq_req               = s.irq;

  chk_reset_imask: assert property (@(posedge clk) $past(rst) && !rst |->
    processor_status_word[`CSF_PSW_I] && !busy)
    else $error("interrupt mask not set after reset");

  chk_irq_delay: assert property (@(posedge clk) disable iff (rst)
    (irq_req != $past(irq_req)) |-> $past(done) && $past(s.irq_pv))
    else $error("interrupt request changed outside instruction end");

  chk_bcd_add: assert property (@(posedge clk) disable iff (rst)
    done && s.op == add_with_carry_op && s.psw[`CSF_PSW_D] &&
    s.opa[3:0] <= 4'h9 && s.opa[7:4] <= 4'h9 && s.opb[3:0] <= 4'h9 && s.opb[7:4] <= 4'h9
    |=> s.res[3:0] <= 4'h9 && s.res[7:4] <= 4'h9 && s.res[15:8] == 8'h00)
    else $error("decimal add result not decimal");

  chk_bcd_sub: assert property (@(posedge clk) disable iff (rst)
    done && is_sub && s.psw[`CSF_PSW_D] &&
    s.opa == 8'h00 && s.opb == 8'h01 && s.psw[`CSF_PSW_C]
    |=> s.res[7:0] == 8'h99 && !s.psw[`CSF_PSW_C])
    else $error("decimal borrow not propagated");

  chk_mul_value: assert property (@(posedge clk) disable iff (rst)
    done && s.op == multiply_op |=> s.res == 16'($past(s.opa)) * 16'($past(s.opb)))
    else $error("multiply result wrong");

  chk_muldiv_psw: assert property (@(posedge clk) disable iff (rst)
    done && (s.op == multiply_op || s.op == divide_op) |=> $stable(processor_status_word))
    else $error("status word changed by multiply or divide");

  chk_instr_len: assert property (@(posedge clk) disable iff (rst)
    busy && !tick |=> $stable(s.cyc) && busy)
    else $error("instruction advanced without phi cycle");

  chk_hs_div: assert property (@(posedge clk) disable iff (rst)
    rise && s.hs |-> tick == (s.div_cnt != 3'h0))
    else $error("high speed phi not oscillator divided by two");

endmodule

// *** verification/csf_core_bench.sv ***
// self-checking bench for csf_core: apb stimulus, arithmetic and timing
// assumes csf_pkg compiled first and csf_consts.svh on the include path
`timescale 1ns/1ps
`include "csf_consts.svh"

module csf_core_bench
  import csf_pkg::*;
();
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        main_osc_input = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, busy, err, d, sb, c;
  logic        hs = 1'b0;
  logic [7:0]  processor_status_word, irq_req, a, b, p0;
  logic [7:0]  irqv = 8'hA5;
  logic [8:0]  ex;
  logic [1:0]  ocnt = 2'h0;
  int          n_errors = 0;
  int          checked = 0;
  int          tick = 0;
  int          cyc;

  csf_core i_csf_core (.clk(clk), .rst(rst), .main_osc_input(main_osc_input),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .processor_status_word(processor_status_word), .busy(busy), .irq_req(irq_req));

  always #2 clk = ~clk;

  // oscillator of 8 clk periods, watchdog
  always @(posedge clk) begin
    ocnt <= ocnt + 2'h1;
    if (ocnt == 2'h3) main_osc_input <= ~main_osc_input;
    tick <= tick + 1;
    if (tick == 60000) begin
      n_errors++;
      complete_run;
    end
  end

  task complete_run;
    $display("errors %0d, checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task cmp_rng(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("wrong value at %0t: %0d cycles, not %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task run(input csf_op_e op, input logic [7:0] x, input logic [7:0] y);
    int n;
    n = (op == multiply_op) ? `CSF_CYC_MUL : (op == divide_op) ? `CSF_CYC_DIV :
        (op >= branch_bit_clear_op) ? `CSF_CYC_BBX : `CSF_CYC_ARITH;
    apb(1'b1, `CSF_ADDR_OPA, {24'h0, x});
    apb(1'b1, `CSF_ADDR_OPB, {24'h0, y});
    apb(1'b1, `CSF_ADDR_CMD, {28'h0, op});
    cyc = 0;
    @(negedge clk);
    while (busy === 1'b1 && cyc < 2000) begin
      @(negedge clk);
      cyc++;
    end
    cmp_rng(cyc, (n - 1) * (hs ? 16 : 64), n * (hs ? 16 : 64) + 8);
    apb(1'b0, `CSF_ADDR_RES, 32'h0);
  endtask

  task do_reset;
    rst <= 1'b1;
    hs = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `CSF_ADDR_PSW, 32'h0);
    cmp({31'h0, processor_status_word[2]}, 32'h1);
    cmp({31'h0, rd[2]}, 32'h1);
  endtask

  // expected {carry, result} of add or subtract
  function automatic logic [8:0] exp_ar(logic s, logic dm, logic [7:0] x, logic [7:0] y,
                                        logic ci);
    int t;
    int cy;
    logic [7:0] r;
    if (!dm) return {1'b0, x} + {1'b0, s ? ~y : y} + 9'(ci);
    cy = ci;
    for (int i = 0; i < 2; i++) begin
      t = s ? int'(x[4*i+:4]) - int'(y[4*i+:4]) - (1 - cy) : int'(x[4*i+:4]) + int'(y[4*i+:4]) + cy;
      cy = s ? (t >= 0) : (t > 9);
      if (s && t < 0) t += 10;
      if (!s && t > 9) t -= 10;
      r[4*i+:4] = t[3:0];
    end
    return {cy[0], r};
  endfunction

  initial begin
    void'($urandom(32'h6e022900));
    do_reset;
    apb(1'b0, 8'h20, 32'h0);
    cmp({31'h0, err}, 32'h1);
    apb(1'b1, `CSF_ADDR_RES, 32'h0);
    cmp({31'h0, err}, 32'h1);
    apb(1'b1, `CSF_ADDR_CLK, 32'h1);
    hs = 1'b1;
    for (int k = 0; k < 8; k++) begin
      if (k == 4) begin
        apb(1'b1, `CSF_ADDR_CLK, 32'h0);
        hs = 1'b0;
      end
      a = 8'($urandom);
      b = (k == 1) ? 8'h00 : 8'($urandom);
      p0 = 8'($urandom) | 8'h28;
      apb(1'b1, `CSF_ADDR_PSW, {24'h0, p0});
      run(k[0] ? divide_op : multiply_op, a, b);
      cmp({24'h0, processor_status_word}, {24'h0, p0});
      cmp(rd, k[0] ? (b == 8'h00 ? {16'h0, a, 8'hFF} : {16'h0, a % b, a / b}) :
          {16'h0, 16'(a) * 16'(b)});
    end
    apb(1'b1, `CSF_ADDR_CLK, 32'h1);
    hs = 1'b1;
    for (int k = 2; k < 6; k++) begin
      run(csf_op_e'(k), 8'h00, 8'h00);
      cmp({31'h0, processor_status_word[k < 4 ? 0 : 3]}, {31'h0, k == 2 || k == 5});
    end
    for (int k = 0; k < 24; k++) begin
      d = k[1];
      sb = k[0];
      c = 1'($urandom);
      a = d ? {4'($urandom % 10), 4'($urandom % 10)} : 8'($urandom);
      b = d ? {4'($urandom % 10), 4'($urandom % 10)} : 8'($urandom);
      if (k == 2) {a, b, c} = {8'h99, 8'h01, 1'b0};
      if (k == 3) {a, b, c} = {8'h00, 8'h01, 1'b1};
      apb(1'b1, `CSF_ADDR_PSW, {24'h0, 4'h0, d, 2'b10, c});
      run(sb ? subtract_with_borrow_op : add_with_carry_op, a, b);
      ex = exp_ar(sb, d, a, b, c);
      cmp({24'h0, rd[7:0]}, {24'h0, ex[7:0]});
      cmp({31'h0, processor_status_word[0]}, {31'h0, ex[8]});
    end
    apb(1'b1, `CSF_ADDR_IRQ, {24'h0, irqv});
    run(set_decimal_op, 8'h00, 8'h00);
    cmp({24'h0, irq_req}, {24'h0, irqv});
    for (int j = 0; j < 8; j++) begin
      run(j[0] ? branch_bit_set_op : branch_bit_clear_op, 8'(j), 8'h00);
      cmp({31'h0, rd[0]}, {31'h0, irqv[j] ~^ j[0]});
    end
    apb(1'b1, `CSF_ADDR_CMD, {28'h0, multiply_op});
    apb(1'b1, `CSF_ADDR_OPA, 32'h0);
    cmp({31'h0, err}, 32'h1);
    while (busy === 1'b1) @(posedge clk);
    apb(1'b1, `CSF_ADDR_PSW, 32'h0);
    do_reset;
    complete_run;
  end
endmodule
